// >>> uesc_cfg.svh
// Constants of the endpoint status and buffer control block.
`ifndef UESC_CFG_SVH
`define UESC_CFG_SVH

// ==========================================================
// Register offsets and reset value
`define UESC_REG_STATUS 8'h50
`define UESC_REG_IMAGE 8'hD0
`define UESC_STATUS_RST 8'h00

// ==========================================================
// Command groups, upper nibble of the command code, and the full 8-bit setup acknowledge code
`define UESC_OP_STALL 4'h4
`define UESC_OP_STATUS 4'h5
`define UESC_OP_VALID 4'h6
`define UESC_OP_CLEAR 4'h7
`define UESC_OP_UNSTALL 4'h8
`define UESC_OP_IMAGE 4'hD
`define UESC_OP_ACK_SETUP 8'hF4

// ==========================================================
// Endpoint indices
`define UESC_EP_CTL_OUT 4'h0
`define UESC_EP_CTL_IN 4'h1
`define UESC_EP_COUNT 16

// ==========================================================
// Status byte field positions
`define UESC_BIT_STALL 7
`define UESC_BIT_FULL1 6
`define UESC_BIT_FULL0 5
`define UESC_BIT_TOGGLE 4
`define UESC_BIT_SETUP_A 3
`define UESC_BIT_SETUP_PRESENT 2
`define UESC_BIT_CPU_BUF 1
`define UESC_BIT_RSVD 0

`endif

// >>> uesc_pkg.sv
// Types shared by the endpoint status and buffer control block.
package uesc_pkg;

    // ==========================================================
    // Port sequencer states
    typedef enum logic [0:0]
    {
        UESC_ST_IDLE = 1'h0,
        UESC_ST_READ = 1'h1
    } uesc_state_type;

endpackage : uesc_pkg

// >>> uesc_sync.sv
// Two-stage synchroniser for the parallel port pins.
`timescale 1ns/10ps
module uesc_sync
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Pins in and synchronised copy out
    input wire logic [10:0] pin_in,
    output logic [10:0] pin_sync
);

    // ==========================================================
    // Stages
    logic [10:0] stage1_r;
    logic [10:0] stage2_r;

    // Strobes idle high, so reset both stages to all ones.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1_r <= 11'h7FF;
            stage2_r <= 11'h7FF;
        end
        else if (clk_en)
        begin
            stage1_r <= pin_in;
            stage2_r <= stage1_r;
        end
    end

    assign pin_sync = stage2_r;

endmodule : uesc_sync

// >>> uesc_ep_cell.sv
// Status and buffer state of one endpoint.
`timescale 1ns/10ps
`include "uesc_cfg.svh"
module uesc_ep_cell
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Configuration
    input wire logic is_in,
    input wire logic dbl,
    // Command pulses
    input wire logic cmd_stall,
    input wire logic cmd_unstall,
    input wire logic cmd_validate,
    input wire logic cmd_clear,
    input wire logic cmd_ack,
    input wire logic rd_clear,
    // USB events
    input wire logic setup_tok,
    input wire logic setup_done,
    input wire logic pkt_done,
    // State out
    output logic [7:0] status,
    output logic nak,
    output logic flush,
    output logic usb_buf
);

    // ==========================================================
    // State
    logic stalled_flag_r;
    logic [1:0] full_r;
    logic next_toggle_r;
    logic setup_a_r;
    logic setup_present_r;
    logic setup_pend_r;
    logic setup_wdone_r;
    logic cpu_buffer_select_r;
    logic usb_sel_r;
    logic flush_r;

    // ==========================================================
    // Next values
    wire flush_now = cmd_unstall | (setup_tok & stalled_flag_r);
    wire [1:0] cpu_oh = cpu_buffer_select_r ? 2'h2 : 2'h1;
    wire [1:0] usb_oh = usb_sel_r ? 2'h2 : 2'h1;
    wire out_fill = (pkt_done & ~is_in) | setup_done;
    wire [1:0] set_v = (cmd_validate ? cpu_oh : 2'h0) | (out_fill ? usb_oh : 2'h0);
    wire [1:0] clr_v = (cmd_clear ? cpu_oh : 2'h0) | ((pkt_done & is_in) ? usb_oh : 2'h0);
    wire [1:0] full_nxt = flush_now ? 2'h0 : ((full_r & ~clr_v) | set_v);
    wire swap_cpu = dbl & (cmd_validate | cmd_clear);
    wire cpu_nxt = flush_now ? 1'h0 : (cpu_buffer_select_r ^ swap_cpu);
    wire usb_nxt = flush_now ? 1'h0 : (usb_sel_r ^ (dbl & (pkt_done | setup_done)));
    wire stall_nxt = cmd_stall | (stalled_flag_r & ~flush_now);
    wire tog_nxt = flush_now ? 1'h0 : (setup_done | (next_toggle_r ^ pkt_done));
    wire pend_nxt = setup_tok | (setup_pend_r & ~(cmd_ack | cmd_stall));
    wire wdone_nxt = setup_done | (setup_wdone_r & ~setup_tok);
    // Only the OUT side holds setup data, so only it can be overwritten.
    wire seta_set = setup_tok & setup_pend_r & ~is_in;
    // A fresh setup_a wins over a read that clears the flag.
    wire seta_nxt = seta_set | (setup_a_r & ~(rd_clear & setup_wdone_r));
    wire present_nxt = setup_done | (setup_present_r & ~(cmd_clear | pkt_done | flush_now));

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stalled_flag_r <= 1'h0;
            full_r <= 2'h0;
            next_toggle_r <= 1'h0;
            setup_a_r <= 1'h0;
            setup_present_r <= 1'h0;
            setup_pend_r <= 1'h0;
            setup_wdone_r <= 1'h0;
            cpu_buffer_select_r <= 1'h0;
            usb_sel_r <= 1'h0;
            flush_r <= 1'h0;
        end
        else if (clk_en)
        begin
            stalled_flag_r <= stall_nxt;
            full_r <= full_nxt;
            next_toggle_r <= tog_nxt;
            setup_a_r <= seta_nxt;
            setup_present_r <= present_nxt;
            setup_pend_r <= pend_nxt;
            setup_wdone_r <= wdone_nxt;
            cpu_buffer_select_r <= cpu_nxt;
            usb_sel_r <= usb_nxt;
            flush_r <= flush_now;
        end
    end

    // ==========================================================
    // Outputs
    assign status = {stalled_flag_r, full_r[1], full_r[0], next_toggle_r, setup_a_r,
                     setup_present_r, cpu_buffer_select_r, 1'h0};
    assign nak = ~is_in & (usb_sel_r ? full_r[1] : full_r[0]);
    assign flush = flush_r;
    assign usb_buf = usb_sel_r;

    // ==========================================================
    // Checks
    property p_stall_set;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && cmd_stall |=> status[`UESC_BIT_STALL];
    endproperty
    a_stall_set: assert property (p_stall_set) else $error("stall not set");

    property p_setup_flush;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && stalled_flag_r && setup_tok && !cmd_stall
        |=> status[7:4] == 4'h0 && flush;
    endproperty
    a_setup_flush: assert property (p_setup_flush) else $error("no flush on setup");

    property p_setup_a;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && setup_tok && setup_pend_r && !is_in |=> status[`UESC_BIT_SETUP_A];
    endproperty
    a_setup_a: assert property (p_setup_a) else $error("setup_a not flagged");

    property p_out_full;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && pkt_done && !is_in && !flush_now && !cmd_clear
        |=> nak || dbl;
    endproperty
    a_out_full: assert property (p_out_full) else $error("out buffer not locked");

    property p_validate;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && cmd_validate && !cpu_buffer_select_r && !flush_now && !pkt_done
        |=> full_r[0] && (cpu_buffer_select_r == $past(dbl));
    endproperty
    a_validate: assert property (p_validate) else $error("validate failed");

endmodule : uesc_ep_cell

// >>> uesc_top.sv
// Endpoint status reads and buffer control commands on the parallel port.
`timescale 1ns/10ps
`include "uesc_cfg.svh"

module uesc_top
(
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Parallel port pins
    input wire logic port_a0,
    input wire logic port_wr_n,
    input wire logic port_rd_n,
    input wire logic [7:0] port_d_in,
    output logic [7:0] port_d_out,
    output logic port_d_oe,
    // USB engine events
    input wire logic [3:0] usb_ep,
    input wire logic usb_setup_tok,
    input wire logic usb_setup_done,
    input wire logic usb_pkt_done,
    // Endpoint configuration
    input wire logic [15:0] ep_dbl,
    input wire logic [15:0] ep_is_in,
    // Endpoint state out
    output logic [15:0] irq_clear,
    output logic [15:0] ep_stall,
    output logic [15:0] ep_nak,
    output logic [15:0] ep_flush,
    output logic [15:0] ep_toggle,
    output logic [15:0] ep_usb_buf
);

    // ==========================================================
    // Pin synchronisation
    logic [10:0] pin_s;
    logic wr_d_r;
    logic rd_d_r;

    uesc_sync u_sync
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .pin_in({port_a0, port_wr_n, port_rd_n, port_d_in}),
        .pin_sync(pin_s)
    );

    wire a0_s = pin_s[10];
    wire wr_s = pin_s[9];
    wire rd_s = pin_s[8];
    wire [7:0] d_s = pin_s[7:0];

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_d_r <= 1'h1;
            rd_d_r <= 1'h1;
        end
        else if (clk_en)
        begin
            wr_d_r <= wr_s;
            rd_d_r <= rd_s;
        end
    end

    wire wr_rise = wr_s & ~wr_d_r;
    wire rd_fall = ~rd_s & rd_d_r;
    wire rd_rise = rd_s & ~rd_d_r;

    // ==========================================================
    // Command decode
    // Data-phase writes are dropped here, so no status bit can be written.
    wire is_cmd = wr_rise & a0_s;
    wire [3:0] op = d_s[7:4];
    wire [3:0] cmd_ep = d_s[3:0];
    wire [15:0] cmd_hot = 16'h0001 << cmd_ep;
    wire ctl_ep = (cmd_ep == `UESC_EP_CTL_OUT) || (cmd_ep == `UESC_EP_CTL_IN);
    logic setup_lock_r;
    wire blocked = setup_lock_r & ctl_ep;
    wire dec_stall = is_cmd && (op == `UESC_OP_STALL);
    wire dec_unstall = is_cmd && (op == `UESC_OP_UNSTALL);
    wire dec_valid = is_cmd && (op == `UESC_OP_VALID) && (cmd_ep != `UESC_EP_CTL_OUT)
                     && !blocked;
    wire dec_clear = is_cmd && (op == `UESC_OP_CLEAR) && (cmd_ep != `UESC_EP_CTL_IN)
                     && !blocked;
    wire dec_ack = is_cmd && (d_s == `UESC_OP_ACK_SETUP);
    wire dec_status = is_cmd && (op == `UESC_OP_STATUS);
    wire dec_image = is_cmd && (op == `UESC_OP_IMAGE);
    wire [15:0] stall_v = dec_stall ? cmd_hot : 16'h0000;
    wire [15:0] unstall_v = dec_unstall ? cmd_hot : 16'h0000;
    wire [15:0] valid_v = dec_valid ? cmd_hot : 16'h0000;
    wire [15:0] clear_v = dec_clear ? cmd_hot : 16'h0000;
    wire [15:0] usb_hot = 16'h0001 << usb_ep;
    wire [15:0] pkt_v = usb_pkt_done ? usb_hot : 16'h0000;

    // ==========================================================
    // Read sequencer
    uesc_pkg::uesc_state_type st_r;
    uesc_pkg::uesc_state_type st_nxt;
    logic [3:0] rd_ep_r;
    logic rd_clr_r;
    logic [7:0] rd_data_r;
    logic [15:0] irq_clear_r;
    logic [7:0] stat_a [0:15];

    wire in_read = (st_r == uesc_pkg::UESC_ST_READ);
    wire read_done = in_read & rd_rise;
    wire [15:0] rd_hot = 16'h0001 << rd_ep_r;
    // Only the status read clears; the image read leaves every bit alone.
    wire [15:0] rd_clr_v = (read_done & rd_clr_r) ? rd_hot : 16'h0000;

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            uesc_pkg::UESC_ST_IDLE:
            begin
                if (dec_status | dec_image)
                    st_nxt = uesc_pkg::UESC_ST_READ;
            end
            uesc_pkg::UESC_ST_READ:
            begin
                if (is_cmd & ~(dec_status | dec_image))
                    st_nxt = uesc_pkg::UESC_ST_IDLE;
                else if (read_done)
                    st_nxt = uesc_pkg::UESC_ST_IDLE;
            end
            default:
            begin
                st_nxt = uesc_pkg::UESC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= uesc_pkg::UESC_ST_IDLE;
            rd_ep_r <= 4'h0;
            rd_clr_r <= 1'h0;
            irq_clear_r <= 16'h0000;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
            irq_clear_r <= rd_clr_v;
            if (dec_status | dec_image)
            begin
                rd_ep_r <= cmd_ep;
                rd_clr_r <= dec_status;
            end
        end
    end

    // The byte is caught when the read strobe falls, so it stays steady on the bus.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_r <= `UESC_STATUS_RST;
        else if (clk_en && in_read && rd_fall)
            rd_data_r <= stat_a[rd_ep_r];
    end

    // ==========================================================
    // Setup lock on the control endpoints
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            setup_lock_r <= 1'h0;
        else if (clk_en)
            setup_lock_r <= usb_setup_tok | (setup_lock_r & ~dec_ack);
    end

    // ==========================================================
    // Endpoint cells
    genvar gi;
    generate
        for (gi = 0; gi < `UESC_EP_COUNT; gi = gi + 1)
        begin : g_ep
            localparam logic IS_CTL = (gi < 2);
            localparam logic IS_CTL_OUT = (gi == 0);
            localparam logic IS_CTL_IN = (gi == 1);
            uesc_ep_cell u_cell
            (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .clk_en(clk_en),
                .is_in(IS_CTL ? IS_CTL_IN : ep_is_in[gi]),
                .dbl(IS_CTL ? 1'h0 : ep_dbl[gi]),
                .cmd_stall(stall_v[gi]),
                .cmd_unstall(unstall_v[gi]),
                .cmd_validate(valid_v[gi]),
                .cmd_clear(clear_v[gi]),
                .cmd_ack(dec_ack & IS_CTL),
                .rd_clear(rd_clr_v[gi]),
                .setup_tok(usb_setup_tok & IS_CTL),
                .setup_done(usb_setup_done & IS_CTL_OUT),
                .pkt_done(pkt_v[gi]),
                .status(stat_a[gi]),
                .nak(ep_nak[gi]),
                .flush(ep_flush[gi]),
                .usb_buf(ep_usb_buf[gi])
            );
            assign ep_stall[gi] = stat_a[gi][`UESC_BIT_STALL];
            assign ep_toggle[gi] = stat_a[gi][`UESC_BIT_TOGGLE];
        end
    endgenerate

    // ==========================================================
    // Outputs
    assign port_d_out = rd_data_r;
    assign port_d_oe = in_read & ~rd_s;
    assign irq_clear = irq_clear_r;

    // ==========================================================
    // Checks
    property p_irq_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && read_done && rd_clr_r |=> irq_clear == (16'h0001 << rd_ep_r);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("pending bit not cleared");

    property p_image_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && read_done && !rd_clr_r |=> irq_clear == 16'h0000;
    endproperty
    a_image_quiet: assert property (p_image_quiet) else $error("image read cleared");

    property p_data_write;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_rise && !a0_s |-> (stall_v | unstall_v | valid_v | clear_v) == 16'h0000;
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write acted");

    property p_lock;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && usb_setup_tok ##1 (!dec_ack)[*2] |-> setup_lock_r && !valid_v[1] && !clear_v[0];
    endproperty
    a_lock: assert property (p_lock) else $error("control buffer not locked");

    property p_oe;
        @(posedge clk_sys) disable iff (!rst_n)
        port_d_oe |-> in_read && !rd_s;
    endproperty
    a_oe: assert property (p_oe) else $error("bus driven outside a read");

    property p_reserved;
        @(posedge clk_sys) disable iff (!rst_n)
        clk_en && in_read && rd_fall |=> port_d_out[`UESC_BIT_RSVD] == 1'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule : uesc_top

// >>> uesc_mcu_model.sv
// Microcontroller model driving the parallel command and data port.
`timescale 1ns/10ps
`include "uesc_cfg.svh"
module uesc_mcu_model
(
    // Clock
    input wire logic clk_sys,
    // Port pins
    output logic port_a0,
    output logic port_wr_n,
    output logic port_rd_n,
    output logic [7:0] port_d_in,
    input wire logic [7:0] port_d_out,
    input wire logic port_d_oe
);
    // ==========================================================
    // Idle pins
    initial
    begin
        port_a0 = 1'b1;
        port_wr_n = 1'b1;
        port_rd_n = 1'b1;
        port_d_in = 8'hA5;
    end

    // ==========================================================
    // Port cycles
    // Strobe phases of five cycles keep the minimum spacing with a cycle to spare.
    task automatic wr(input logic [7:0] code, input logic a0);
        @(negedge clk_sys);
        port_a0 = a0;
        port_d_in = code;
        port_wr_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        port_wr_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        // The bus is let go, so the code must not linger on it.
        port_d_in = ~code;
    endtask : wr

    task automatic rd(output logic [7:0] b);
        int i;
        @(negedge clk_sys);
        port_a0 = 1'b0;
        port_rd_n = 1'b0;
        b = 'x;
        for (i = 0; i < 8 && port_d_oe !== 1'b1; i++)
            @(negedge clk_sys);
        @(negedge clk_sys);
        // A bus nobody drives shows the inverse, so a missed read cannot pass.
        b = port_d_oe ? port_d_out : ~port_d_out;
        repeat (4) @(negedge clk_sys);
        port_rd_n = 1'b1;
        repeat (6) @(negedge clk_sys);
    endtask : rd

    // ==========================================================
    // Firmware habits
    task automatic unstall(input logic [3:0] n);
        wr({`UESC_OP_UNSTALL, n}, 1'b1);
        wr({`UESC_OP_UNSTALL, n}, 1'b1);
    endtask : unstall

    // The image read is used so that the setup_a flag is not cleared by looking.
    task automatic ack_setup(output logic ok);
        logic [7:0] b;
        wr({`UESC_OP_IMAGE, `UESC_EP_CTL_OUT}, 1'b1);
        rd(b);
        ok = ~b[`UESC_BIT_SETUP_A];
        if (ok)
            wr(`UESC_OP_ACK_SETUP, 1'b1);
    endtask : ack_setup
endmodule : uesc_mcu_model

// >>> usb_endpoint_status_control_tb_top.sv
// Self-checking testbench of the endpoint status and buffer control block.
`timescale 1ns/10ps
`include "uesc_cfg.svh"
module usb_endpoint_status_control_tb_top;
    // ==========================================================
    // Signals
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic port_a0, port_wr_n, port_rd_n, port_d_oe;
    logic [7:0] port_d_in, port_d_out;
    logic [3:0] usb_ep = 4'h0;
    logic usb_setup_tok = 1'b0;
    logic usb_setup_done = 1'b0;
    logic usb_pkt_done = 1'b0;
    logic [15:0] ep_dbl = 16'h0000;
    logic [15:0] ep_is_in = 16'h0000;
    logic [15:0] irq_clear, ep_stall, ep_nak, ep_flush, ep_toggle, ep_usb_buf;
    logic [15:0] irq_acc = 16'h0000;
    logic [15:0] flush_acc = 16'h0000;
    int n_fail = 0;
    int checks_done = 0;

    always #10 clk_sys = ~clk_sys;

    // Pulses last one cycle, so they are gathered here and read later.
    always @(posedge clk_sys)
    begin
        irq_acc <= irq_acc | irq_clear;
        flush_acc <= flush_acc | ep_flush;
    end

    uesc_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .port_a0(port_a0),
        .port_wr_n(port_wr_n), .port_rd_n(port_rd_n), .port_d_in(port_d_in),
        .port_d_out(port_d_out), .port_d_oe(port_d_oe), .usb_ep(usb_ep),
        .usb_setup_tok(usb_setup_tok), .usb_setup_done(usb_setup_done),
        .usb_pkt_done(usb_pkt_done), .ep_dbl(ep_dbl), .ep_is_in(ep_is_in),
        .irq_clear(irq_clear), .ep_stall(ep_stall), .ep_nak(ep_nak), .ep_flush(ep_flush),
        .ep_toggle(ep_toggle), .ep_usb_buf(ep_usb_buf));

    uesc_mcu_model u_mcu (.clk_sys(clk_sys), .port_a0(port_a0), .port_wr_n(port_wr_n),
        .port_rd_n(port_rd_n), .port_d_in(port_d_in), .port_d_out(port_d_out),
        .port_d_oe(port_d_oe));

    // ==========================================================
    // Helpers
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [7:0] sbyte(input logic s, f1, f0, t, o, p, c);
        return {s, f1, f0, t, o, p, c, 1'b0};
    endfunction : sbyte

    task automatic img(input logic [3:0] n, input logic [7:0] exp);
        logic [7:0] b;
        u_mcu.wr({`UESC_OP_IMAGE, n}, 1'b1);
        u_mcu.rd(b);
        check("image byte", exp, b);
    endtask : img

    task automatic sts(input logic [3:0] n, input logic [7:0] exp);
        logic [7:0] b;
        u_mcu.wr({`UESC_OP_STATUS, n}, 1'b1);
        u_mcu.rd(b);
        check("status byte", exp, b);
    endtask : sts

    task automatic ev(input logic [2:0] k, input logic [3:0] ep);
        @(negedge clk_sys);
        usb_ep = ep;
        {usb_setup_tok, usb_setup_done, usb_pkt_done} = k;
        @(negedge clk_sys);
        {usb_setup_tok, usb_setup_done, usb_pkt_done} = 3'b000;
        repeat (3) @(negedge clk_sys);
    endtask : ev

    task automatic print_verdict();
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Watchdog, about sixteen times the expected run
    initial
    begin
        #400000;
        n_fail++;
        print_verdict();
    end

    // ==========================================================
    // Tests
    initial
    begin
        int n;
        logic ok;
        void'($urandom(75));
        ep_is_in = 16'($urandom);
        ep_dbl = 16'($urandom);
        // Endpoint 2 is a single OUT buffer and endpoint 3 a double IN buffer.
        ep_is_in[3:2] = 2'b10;
        ep_dbl[3:2] = 2'b10;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        for (n = 0; n < 16; n++)
            img(n[3:0], 8'h00);
        check("image read irq", 16'h0000, irq_acc);
        repeat (3)
        begin
            n = $urandom_range(15);
            u_mcu.wr({`UESC_OP_STALL, n[3:0]}, 1'b0);
            check("data phase write", 1'b0, ep_stall[n]);
            u_mcu.wr({`UESC_OP_STALL, n[3:0]}, 1'b1);
            check("stall pin", 1'b1, ep_stall[n]);
            img(n[3:0], sbyte(1, 0, 0, 0, 0, 0, 0));
            flush_acc = 16'h0000;
            u_mcu.unstall(n[3:0]);
            check("unstall flush", 1'b1, flush_acc[n]);
            img(n[3:0], 8'h00);
        end
        irq_acc = 16'h0000;
        ev(3'b001, 4'h2);
        check("out nak", 1'b1, ep_nak[2]);
        check("toggle pin", 1'b1, ep_toggle[2]);
        img(4'h2, sbyte(0, 0, 1, 1, 0, 0, 0));
        u_mcu.wr({`UESC_OP_CLEAR, 4'h2}, 1'b1);
        check("nak after clear", 1'b0, ep_nak[2]);
        sts(4'h2, sbyte(0, 0, 0, 1, 0, 0, 0));
        check("status read irq", 16'h0004, irq_acc);
        u_mcu.wr({`UESC_OP_VALID, 4'h3}, 1'b1);
        img(4'h3, sbyte(0, 0, 1, 0, 0, 0, 1));
        u_mcu.wr({`UESC_OP_VALID, 4'h3}, 1'b1);
        img(4'h3, sbyte(0, 1, 1, 0, 0, 0, 0));
        ev(3'b001, 4'h3);
        check("usb buffer", 16'h0008, ep_usb_buf & 16'h000C);
        img(4'h3, sbyte(0, 1, 0, 1, 0, 0, 0));
        u_mcu.wr({`UESC_OP_STALL, `UESC_EP_CTL_IN}, 1'b1);
        flush_acc = 16'h0000;
        ev(3'b100, 4'h0);
        check("setup unstall", 1'b0, ep_stall[1]);
        check("setup flush", 1'b1, flush_acc[1]);
        ev(3'b010, 4'h0);
        u_mcu.wr({`UESC_OP_VALID, `UESC_EP_CTL_IN}, 1'b1);
        img(4'h1, 8'h00);
        img(4'h0, sbyte(0, 0, 1, 1, 0, 1, 0));
        ev(3'b100, 4'h0);
        ev(3'b010, 4'h0);
        u_mcu.ack_setup(ok);
        check("setup_a seen", 1'b0, ok);
        sts(4'h0, sbyte(0, 0, 1, 1, 1, 1, 0));
        img(4'h0, sbyte(0, 0, 1, 1, 0, 1, 0));
        u_mcu.ack_setup(ok);
        check("setup acknowledged", 1'b1, ok);
        u_mcu.wr({`UESC_OP_VALID, `UESC_EP_CTL_IN}, 1'b1);
        img(4'h1, sbyte(0, 0, 1, 0, 0, 0, 0));
        u_mcu.wr({`UESC_OP_CLEAR, `UESC_EP_CTL_OUT}, 1'b1);
        img(4'h0, sbyte(0, 0, 0, 1, 0, 0, 0));
        u_mcu.wr({`UESC_OP_VALID, `UESC_EP_CTL_OUT}, 1'b1);
        img(4'h0, sbyte(0, 0, 0, 1, 0, 0, 0));
        u_mcu.wr({`UESC_OP_CLEAR, `UESC_EP_CTL_IN}, 1'b1);
        img(4'h1, sbyte(0, 0, 1, 0, 0, 0, 0));
        print_verdict();
    end
endmodule : usb_endpoint_status_control_tb_top
